// >>> core/pmo_pkg.sv
/*
 * constants, register map and carrier types for the pull-up, peripheral
 * select and output write gating block of a 32-line i/o port.
 * assumes one 50 MHz clock and a simple strobe-based register port.
 */
// Notes on behaviour
// - writing 1 to a pullup_disable bit turns that line's pull-up off; 0 does nothing.
// - writing 1 to a pullup_enable bit turns that line's pull-up on; 0 does nothing.
// - pullup_state reads 0 when pull-up is active, 1 when disabled.
// - writing 1 to periph_first_select routes that line to function A.
// - writing 1 to periph_second_select routes that line to function B.
// - periph_choice_state reads 0 for function A, 1 for function B.
// - writing 1 to out_write_gate_enable lets output level writes change that line.
// - writing 1 to out_write_gate_disable blocks output level writes for that line.
// - out_write_gate_state reads 1 when output level writes change the line.
package pmo_pkg;

   localparam int unsigned PMO_LINES = 32;
   localparam int unsigned PMO_AW    = 8;

   typedef logic [PMO_LINES-1:0] pmo_line_t;
   typedef logic [PMO_AW-1:0]    pmo_addr_t;

   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam pmo_addr_t PMO_PULLUP_DISABLE_OFS   = 8'h00;
   localparam pmo_addr_t PMO_PULLUP_ENABLE_OFS    = 8'h04;
   localparam pmo_addr_t PMO_PULLUP_STATE_OFS     = 8'h08;
   localparam pmo_addr_t PMO_PERIPH_FIRST_OFS     = 8'h10;
   localparam pmo_addr_t PMO_PERIPH_SECOND_OFS    = 8'h14;
   localparam pmo_addr_t PMO_PERIPH_CHOICE_OFS    = 8'h18;
   localparam pmo_addr_t PMO_GATE_ENABLE_OFS      = 8'h20;
   localparam pmo_addr_t PMO_GATE_DISABLE_OFS     = 8'h24;
   localparam pmo_addr_t PMO_GATE_STATE_OFS       = 8'h28;
   localparam pmo_addr_t PMO_OUTPUT_LEVEL_OFS     = 8'h30;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam pmo_line_t PMO_PULLUP_OFF_RST   = 32'h0000_0000;
   localparam pmo_line_t PMO_CHOICE_RST       = 32'h0000_0000;
   localparam pmo_line_t PMO_GATE_RST         = 32'h0000_0000;
   localparam pmo_line_t PMO_LEVEL_RST        = 32'h0000_0000;
   localparam logic [31:0] PMO_RDATA_RST      = 32'h0000_0000;

   typedef struct packed {
      pmo_addr_t   addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pmo_bus_s;

   typedef struct packed {
      pmo_line_t pullup_on;
      pmo_line_t sel_second;
      pmo_line_t level;
   } pmo_pad_s;

endpackage

// >>> core/pmo_setclr.sv
/*
 * bank of per-line state bits with set and clear strobes.
 * assumes set and clear come from the same clock domain.
 */
`timescale 1ns/1ps
module pmo_setclr
   import pmo_pkg::*;
#(
   parameter pmo_line_t RST_VAL = 32'h0000_0000
)
(
   input  wire logic      clk_in,
   input  wire logic      arst_n_in,
   input  wire logic      set_in,
   input  wire logic      clr_in,
   input  wire pmo_line_t mask_in,
   output      pmo_line_t state_out
);

   pmo_line_t state_q;
   pmo_line_t state_d;

   // ------------------------------------------------------------------
   // per-line update
   // ------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PMO_LINES; g++)
      begin : g_line
         always_comb
         begin
            state_d[g] = state_q[g];
            if (set_in && mask_in[g])
            begin
               state_d[g] = 1'b1;
            end
            else if (clr_in && mask_in[g])
            begin
               state_d[g] = 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state_q <= RST_VAL;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign state_out = state_q;

endmodule

// >>> core/pmo_top.sv
/*
 * pull-up control, peripheral a/b selection and output write gating
 * for 32 i/o lines, with a gated output level register.
 * assumes a one-cycle strobe register port; strobes never overlap.
 */
`timescale 1ns/1ps
module pmo_top
   import pmo_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   input  wire pmo_addr_t   addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output      logic [31:0] rdata_out,
   output      pmo_line_t   pullup_on_out,
   output      pmo_line_t   sel_second_out,
   output      pmo_line_t   level_out
);

   // ------------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------------
   pmo_bus_s bus;
   assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

   logic wr_pu_dis;
   logic wr_pu_en;
   logic wr_sel_a;
   logic wr_sel_b;
   logic wr_gate_en;
   logic wr_gate_dis;
   logic wr_level;

   assign wr_pu_dis   = bus.wr && (bus.addr == PMO_PULLUP_DISABLE_OFS);
   assign wr_pu_en    = bus.wr && (bus.addr == PMO_PULLUP_ENABLE_OFS);
   assign wr_sel_a    = bus.wr && (bus.addr == PMO_PERIPH_FIRST_OFS);
   assign wr_sel_b    = bus.wr && (bus.addr == PMO_PERIPH_SECOND_OFS);
   assign wr_gate_en  = bus.wr && (bus.addr == PMO_GATE_ENABLE_OFS);
   assign wr_gate_dis = bus.wr && (bus.addr == PMO_GATE_DISABLE_OFS);
   assign wr_level    = bus.wr && (bus.addr == PMO_OUTPUT_LEVEL_OFS);

   // ------------------------------------------------------------------
   // state banks
   // ------------------------------------------------------------------
   pmo_line_t pullup_off;
   pmo_line_t choice;
   pmo_line_t gate;

   // disable sets the off bit, enable clears it
   pmo_setclr #(.RST_VAL(PMO_PULLUP_OFF_RST)) u_pullup
   (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .set_in    (wr_pu_dis),
      .clr_in    (wr_pu_en),
      .mask_in   (bus.wdata),
      .state_out (pullup_off)
   );

   pmo_setclr #(.RST_VAL(PMO_CHOICE_RST)) u_choice
   (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .set_in    (wr_sel_b),
      .clr_in    (wr_sel_a),
      .mask_in   (bus.wdata),
      .state_out (choice)
   );

   pmo_setclr #(.RST_VAL(PMO_GATE_RST)) u_gate
   (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .set_in    (wr_gate_en),
      .clr_in    (wr_gate_dis),
      .mask_in   (bus.wdata),
      .state_out (gate)
   );

   // ------------------------------------------------------------------
   // gated output level
   // ------------------------------------------------------------------
   pmo_line_t level_q;
   pmo_line_t level_d;

   always_comb
   begin
      level_d = level_q;
      if (wr_level)
      begin
         // only gated lines take the written value
         level_d = (bus.wdata & gate) | (level_q & ~gate);
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         level_q <= PMO_LEVEL_RST;
      end
      else
      begin
         level_q <= level_d;
      end
   end

   // ------------------------------------------------------------------
   // read path
   // ------------------------------------------------------------------
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (bus.rd)
      begin
         case (bus.addr)
            PMO_PULLUP_STATE_OFS:  rdata_d = pullup_off;
            PMO_PERIPH_CHOICE_OFS: rdata_d = choice;
            PMO_GATE_STATE_OFS:    rdata_d = gate;
            PMO_OUTPUT_LEVEL_OFS:  rdata_d = level_q;
            default:               rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rdata_q <= PMO_RDATA_RST;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // ------------------------------------------------------------------
   // pad side
   // ------------------------------------------------------------------
   pmo_pad_s pad;
   assign pad = '{pullup_on: ~pullup_off, sel_second: choice, level: level_q};

   assign rdata_out      = rdata_q;
   assign pullup_on_out  = pad.pullup_on;
   assign sel_second_out = pad.sel_second;
   assign level_out      = pad.level;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);

   pullup_off_a: assert property (wr_pu_dis |=> ((pullup_on_out & $past(wdata_in)) == 32'h0))
      else $error("pull-up still on after disable");
   pullup_on_a: assert property (wr_pu_en |=> ((~pullup_on_out & $past(wdata_in)) == 32'h0))
      else $error("pull-up still off after enable");
   pullup_keep_a: assert property ((wr_pu_dis || wr_pu_en) |=>
      ((pullup_on_out & ~$past(wdata_in)) == ($past(pullup_on_out) & ~$past(wdata_in))))
      else $error("pull-up changed on unwritten line");
   pullup_read_a: assert property (rd_in && addr_in == PMO_PULLUP_STATE_OFS |=>
      rdata_out == ~pullup_on_out)
      else $error("pull-up state read wrong");
   sel_first_a: assert property (wr_sel_a |=> ((sel_second_out & $past(wdata_in)) == 32'h0))
      else $error("line not routed to function a");
   sel_second_a: assert property (wr_sel_b |=> ((~sel_second_out & $past(wdata_in)) == 32'h0))
      else $error("line not routed to function b");
   choice_read_a: assert property (rd_in && addr_in == PMO_PERIPH_CHOICE_OFS |=>
      rdata_out == sel_second_out)
      else $error("choice state read wrong");
   gate_write_a: assert property (wr_gate_en ##1 wr_level |=>
      ((level_out ^ $past(wdata_in)) & $past(wdata_in, 2)) == 32'h0)
      else $error("gated line missed level write");
   gate_block_a: assert property (wr_gate_dis ##1 wr_level |=>
      ((level_out ^ $past(level_out)) & $past(wdata_in, 2)) == 32'h0)
      else $error("blocked line changed on level write");
   gate_read_a: assert property (rd_in && addr_in == PMO_GATE_STATE_OFS |=>
      rdata_out == $past(gate))
      else $error("gate state read wrong");
   stable_a: assert property (!wr_in |=> $stable(gate) && $stable(choice))
      else $error("state moved without a write");

   pu_cov_c: cover property (wr_pu_dis ##1 wr_pu_en);
   sel_cov_c: cover property (wr_sel_b ##[1:3] rd_in);
   gate_cov_c: cover property (wr_gate_en ##1 wr_level ##1 wr_gate_dis ##1 wr_level);

endmodule

// >>> tb/pmo_pad_model.sv
/*
 * pad-side partner: routing and pull level as the pads see them.
 * assumes the pad carrier struct of the package.
 */
`timescale 1ns/1ps
module pmo_pad_model
   import pmo_pkg::*;
(
   input  wire pmo_pad_s  pad_in,
   output      pmo_line_t a_route_out,
   output      pmo_line_t pulled_out
);
   // lines not handed to function b stay with function a
   assign a_route_out = ~pad_in.sel_second;
   assign pulled_out  = pad_in.pullup_on;
endmodule

// >>> tb/testbench.sv
/*
 * self-checking bench: random register traffic against a behavioural model.
 * assumes one-cycle strobes and read data in the following cycle only.
 */
`timescale 1ns/1ps
module testbench
   import pmo_pkg::*;
;
   logic        clk_in;
   logic        arst_n_in;
   pmo_addr_t   addr_in;
   logic [31:0] wdata_in;
   logic        wr_in;
   logic        rd_in;
   logic [31:0] rdata_out;
   pmo_line_t   pullup_on_out;
   pmo_line_t   sel_second_out;
   pmo_line_t   level_out;
   pmo_line_t   a_route;
   pmo_line_t   pulled;
   pmo_pad_s    pad_w;
   pmo_line_t   m_pu_off;
   pmo_line_t   m_sel;
   pmo_line_t   m_gate;
   pmo_line_t   m_lvl;
   logic [31:0] m_rexp;
   int          failures;
   int          cmp_count;
   int          kind;
   // two unmapped places at the end
   pmo_addr_t   tbl[$] = '{PMO_PULLUP_DISABLE_OFS, PMO_PULLUP_ENABLE_OFS, PMO_PULLUP_STATE_OFS,
      PMO_PERIPH_FIRST_OFS, PMO_PERIPH_SECOND_OFS, PMO_PERIPH_CHOICE_OFS, PMO_GATE_ENABLE_OFS,
      PMO_GATE_DISABLE_OFS, PMO_GATE_STATE_OFS, PMO_OUTPUT_LEVEL_OFS, 8'h0c, 8'h3c};

   pmo_top u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .pullup_on_out(pullup_on_out), .sel_second_out(sel_second_out), .level_out(level_out));

   assign pad_w = '{pullup_on: pullup_on_out, sel_second: sel_second_out, level: level_out};

   pmo_pad_model u_pad (.pad_in(pad_w), .a_route_out(a_route), .pulled_out(pulled));

   // ------------------------------------------------------------
   // clock, verdict, comparison
   // ------------------------------------------------------------
   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // one strobe cycle, changed just after a rising edge
   task automatic bus_op(input logic w, input pmo_addr_t a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= w;
      rd_in    <= !w;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ------------------------------------------------------------
   // behavioural model, updated on the same edges as the design
   // ------------------------------------------------------------
   always @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         m_pu_off = '0;
         m_sel    = '0;
         m_gate   = '0;
         m_lvl    = '0;
         m_rexp   = '0;
      end
      else
      begin
         m_rexp = '0;
         if (rd_in)
            case (addr_in)
               PMO_PULLUP_STATE_OFS:  m_rexp = m_pu_off;
               PMO_PERIPH_CHOICE_OFS: m_rexp = m_sel;
               PMO_GATE_STATE_OFS:    m_rexp = m_gate;
               PMO_OUTPUT_LEVEL_OFS:  m_rexp = m_lvl;
               default:               m_rexp = '0;
            endcase
         if (wr_in)
            case (addr_in)
               PMO_PULLUP_DISABLE_OFS: m_pu_off = m_pu_off | wdata_in;
               PMO_PULLUP_ENABLE_OFS:  m_pu_off = m_pu_off & ~wdata_in;
               PMO_PERIPH_FIRST_OFS:   m_sel    = m_sel & ~wdata_in;
               PMO_PERIPH_SECOND_OFS:  m_sel    = m_sel | wdata_in;
               PMO_GATE_ENABLE_OFS:    m_gate   = m_gate | wdata_in;
               PMO_GATE_DISABLE_OFS:   m_gate   = m_gate & ~wdata_in;
               PMO_OUTPUT_LEVEL_OFS:   m_lvl    = (m_lvl & ~m_gate) | (wdata_in & m_gate);
               default:                m_lvl    = m_lvl;
            endcase
      end
   end

   always @(negedge clk_in)
   begin
      if (arst_n_in === 1'b1)
      begin
         check(pullup_on_out, ~m_pu_off);
         check(sel_second_out, m_sel);
         check(level_out, m_lvl);
         check(rdata_out, m_rexp);
         check(a_route, ~m_sel);
         check(pulled, ~m_pu_off);
      end
   end

   // ------------------------------------------------------------
   // stimulus: reads of every place, then random back-to-back traffic
   // ------------------------------------------------------------
   initial
   begin
      arst_n_in = 1'b0;
      addr_in   = '0;
      wdata_in  = '0;
      wr_in     = 1'b0;
      rd_in     = 1'b0;
      failures  = 0;
      cmp_count = 0;
      void'($urandom(32'h7e170551));
      repeat (10) @(posedge clk_in);
      arst_n_in <= 1'b1;
      // directed pairs: gate then level, set then clear, select then read
      bus_op(1'b1, PMO_GATE_ENABLE_OFS, $urandom());
      bus_op(1'b1, PMO_OUTPUT_LEVEL_OFS, $urandom());
      bus_op(1'b1, PMO_GATE_DISABLE_OFS, $urandom());
      bus_op(1'b1, PMO_OUTPUT_LEVEL_OFS, $urandom());
      bus_op(1'b1, PMO_PULLUP_DISABLE_OFS, $urandom());
      bus_op(1'b1, PMO_PULLUP_ENABLE_OFS, $urandom());
      bus_op(1'b1, PMO_PERIPH_SECOND_OFS, $urandom());
      bus_op(1'b0, PMO_PERIPH_CHOICE_OFS, 32'h0000_0000);
      bus_op(1'b0, PMO_GATE_STATE_OFS, 32'h0000_0000);
      for (int i = 0; i < 400; i++)
      begin
         @(posedge clk_in);
         kind = (i < 12) ? 1 : int'($urandom_range(2));
         addr_in  <= (i < 12) ? tbl[i] : tbl[$urandom_range(11)];
         wdata_in <= $urandom();
         wr_in    <= (kind == 0);
         rd_in    <= (kind == 1);
      end
      // mid-run reset, then every place read back at its reset value
      @(posedge clk_in);
      wr_in     <= 1'b0;
      rd_in     <= 1'b0;
      arst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      arst_n_in <= 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         bus_op(1'b0, tbl[i], $urandom());
      end
      @(posedge clk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      give_verdict();
   end

   initial
   begin
      #(1000 * 20);
      failures++;
      give_verdict();
   end
endmodule
